// [bzm_map.vh]
// register map, field positions, reset values and timing counts of the buzzer block
`ifndef BZM_MAP_VH
`define BZM_MAP_VH
// ----------------------------------------------------------------
// register indexes (byte address is four times the index)
// ----------------------------------------------------------------
`define BZM_IDX_A_FRQ_LO 16'hA040
`define BZM_IDX_A_FRQ_HI 16'hA041
`define BZM_IDX_A_LEN 16'hA042
`define BZM_IDX_A_GAP 16'hA043
`define BZM_IDX_B_FRQ_LO 16'hA044
`define BZM_IDX_B_FRQ_HI 16'hA045
`define BZM_IDX_B_LEN 16'hA046
`define BZM_IDX_B_GAP 16'hA047
`define BZM_IDX_TONE_CTRL 16'hA048
`define BZM_IDX_PWR_WIN 16'hA049
`define BZM_IDX_TU_CFG 16'hA04A
`define BZM_IDX_IRQ_STAT 16'hA04B
`define BZM_IDX_IRQ_MASK 16'hA04C
// ----------------------------------------------------------------
// tone_control fields
// ----------------------------------------------------------------
`define BZM_TC_ENABLE 7
`define BZM_TC_INVERT 6
`define BZM_TC_B_IRQ_EN 5
`define BZM_TC_A_IRQ_EN 4
`define BZM_TC_B_FLAG 3
`define BZM_TC_A_FLAG 2
`define BZM_TC_B_GO 1
`define BZM_TC_A_GO 0
// ----------------------------------------------------------------
// time_unit_config fields
// ----------------------------------------------------------------
`define BZM_TU_HI 7
`define BZM_TU_LO 6
`define BZM_TU_TONE_BASE_SELECT 4
`define BZM_TU_PW_IRQ_EN 1
`define BZM_TU_PW_FLAG 0
// ----------------------------------------------------------------
// interrupt status and mask bits
// ----------------------------------------------------------------
`define BZM_IRQ_A_END 0
`define BZM_IRQ_B_END 1
`define BZM_IRQ_PWR 2
// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define BZM_RST_BYTE 8'h00
`define BZM_SLOW_KHZ 32
`define BZM_UNIT_MS 1
`define BZM_TICKS_PER_UNIT (`BZM_SLOW_KHZ * `BZM_UNIT_MS)
`define BZM_BASE_DIV_SLOW 64
`define BZM_BASE_DIV_FAST 32
`endif

// [bzm_top.v]
// buzzer and melody controller with avalon-mm register slave
//
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/1ps
`include "bzm_map.vh"

// ----------------------------------------------------------------
// time unit tick generator
// ----------------------------------------------------------------
module bzm_unit (
  input wire clk,
  input wire reset_n,
  input wire restart,
  input wire slow_rise,
  input wire [1:0] time_unit,
  output reg tick_q
);
  reg [7:0] cnt_q;
  wire [31:0] span;

  // slow clock edges per unit less one, doubled per unit step; low byte is the limit
  assign span = (`BZM_TICKS_PER_UNIT << time_unit) - 1;

  // count slow edges, restart aligns the unit to a note start
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= 8'h00;
      tick_q <= 1'b0;
    end else if (restart) begin
      cnt_q <= 8'h00;
      tick_q <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (slow_rise) begin
        if (cnt_q == span[7:0]) begin
          cnt_q <= 8'h00;
          tick_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 8'h01;
        end
      end
    end
  end
endmodule // bzm_unit

// ----------------------------------------------------------------
// top level
// ----------------------------------------------------------------
module bzm_top (
  input wire clk,
  input wire reset_n,
  input wire [17:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire slow_clock_32k,
  output reg tone_output_pin,
  output reg power_window_active,
  output reg irq
);
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_TONE = 2'd1;
  localparam [1:0] ST_GAP = 2'd2;

  reg [11:0] note_a_divider_q, note_b_divider_q;
  reg [7:0] note_a_length_count_q, note_b_length_count_q;
  reg [7:0] note_a_gap_count_q, note_b_gap_count_q;
  reg [7:0] power_window_count_q;
  reg tone_ctrl_enable_q, tone_out_invert_q;
  reg note_a_end_irq_enable_q, note_b_end_irq_enable_q;
  reg note_a_end_flag_q, note_b_end_flag_q;
  reg note_a_go_q, note_b_go_q;
  reg [1:0] time_unit_q;
  reg tone_base_select_q, power_window_irq_enable_q, power_window_flag_q;
  reg [2:0] irq_stat_q, irq_mask_q;
  reg [1:0] state_q;
  reg cur_b_q;
  reg [7:0] seg_cnt_q;
  reg [7:0] pw_cnt_q;
  reg pw_run_q;
  reg slow_q;
  reg [4:0] pre_q;
  reg [11:0] tone_cnt_q;
  reg tone_q;

  wire [15:0] idx = avs_address[17:2];
  wire wr_go = avs_write && !avs_waitrequest;
  wire rd_go = avs_read && !avs_waitrequest;
  wire wr_tc = wr_go && idx == `BZM_IDX_TONE_CTRL;
  wire wr_tu = wr_go && idx == `BZM_IDX_TU_CFG;
  wire [7:0] wd = avs_writedata[7:0];
  wire en_next = wr_tc ? wd[`BZM_TC_ENABLE] : tone_ctrl_enable_q;
  wire slow_rise = slow_clock_32k && !slow_q;
  wire unit_tick, pw_tick;

  // ----------------------------------------------------------------
  // sequencer decisions
  // ----------------------------------------------------------------
  wire go_a = note_a_go_q || (wr_tc && wd[`BZM_TC_A_GO]);
  wire go_b = note_b_go_q || (wr_tc && wd[`BZM_TC_B_GO]);
  wire seg_done = seg_cnt_q == 8'h00;
  wire note_end = state_q == ST_GAP && seg_done;
  // after a note, the other armed note follows, else the sequencer returns to idle
  wire done_a = note_end && !cur_b_q;
  wire done_b = note_end && cur_b_q;
  wire rest_a = go_a && !done_a;
  wire rest_b = go_b && !done_b;
  wire start = tone_ctrl_enable_q &&
               ((state_q == ST_IDLE && (go_a || go_b)) ||
                (note_end && (rest_a || rest_b)));
  // from idle A wins; on completion the other note wins
  wire next_b = (state_q == ST_IDLE) ? !go_a :
                (cur_b_q ? !rest_a : rest_b);
  wire [11:0] div_sel = cur_b_q ? note_b_divider_q : note_a_divider_q;
  wire [4:0] pre_lim = tone_base_select_q ? 5'd31 : 5'd15;

  bzm_unit u_seg_unit (
    .clk(clk),
    .reset_n(reset_n),
    .restart(start || !tone_ctrl_enable_q),
    .slow_rise(slow_rise),
    .time_unit(time_unit_q),
    .tick_q(unit_tick)
  );

  bzm_unit u_pw_unit (
    .clk(clk),
    .reset_n(reset_n),
    .restart(start || !tone_ctrl_enable_q),
    .slow_rise(slow_rise),
    .time_unit(time_unit_q),
    .tick_q(pw_tick)
  );

  // ----------------------------------------------------------------
  // avalon slave handshake: one wait cycle per access
  // ----------------------------------------------------------------
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= 32'h0000_0000;
        if (idx == `BZM_IDX_A_FRQ_LO) begin
          avs_readdata[7:0] <= note_a_divider_q[7:0];
        end else if (idx == `BZM_IDX_A_FRQ_HI) begin
          avs_readdata[3:0] <= note_a_divider_q[11:8];
        end else if (idx == `BZM_IDX_A_LEN) begin
          avs_readdata[7:0] <= note_a_length_count_q;
        end else if (idx == `BZM_IDX_A_GAP) begin
          avs_readdata[7:0] <= note_a_gap_count_q;
        end else if (idx == `BZM_IDX_B_FRQ_LO) begin
          avs_readdata[7:0] <= note_b_divider_q[7:0];
        end else if (idx == `BZM_IDX_B_FRQ_HI) begin
          avs_readdata[3:0] <= note_b_divider_q[11:8];
        end else if (idx == `BZM_IDX_B_LEN) begin
          avs_readdata[7:0] <= note_b_length_count_q;
        end else if (idx == `BZM_IDX_B_GAP) begin
          avs_readdata[7:0] <= note_b_gap_count_q;
        end else if (idx == `BZM_IDX_TONE_CTRL) begin
          // playing status in the go positions
          avs_readdata[7:0] <= {tone_ctrl_enable_q, tone_out_invert_q,
                                note_b_end_irq_enable_q, note_a_end_irq_enable_q,
                                note_b_end_flag_q, note_a_end_flag_q,
                                state_q != ST_IDLE && cur_b_q,
                                state_q != ST_IDLE && !cur_b_q};
        end else if (idx == `BZM_IDX_PWR_WIN) begin
          avs_readdata[7:0] <= power_window_count_q;
        end else if (idx == `BZM_IDX_TU_CFG) begin
          avs_readdata[7:0] <= {time_unit_q, 1'b0, tone_base_select_q, 2'b00,
                                power_window_irq_enable_q, power_window_flag_q};
        end else if (idx == `BZM_IDX_IRQ_STAT) begin
          avs_readdata[2:0] <= irq_stat_q;
        end else if (idx == `BZM_IDX_IRQ_MASK) begin
          avs_readdata[2:0] <= irq_mask_q;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // plain configuration registers
  // ----------------------------------------------------------------
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      note_a_divider_q <= 12'h000;
      note_b_divider_q <= 12'h000;
      note_a_length_count_q <= `BZM_RST_BYTE;
      note_b_length_count_q <= `BZM_RST_BYTE;
      note_a_gap_count_q <= `BZM_RST_BYTE;
      note_b_gap_count_q <= `BZM_RST_BYTE;
      power_window_count_q <= `BZM_RST_BYTE;
      tone_ctrl_enable_q <= 1'b0;
      tone_out_invert_q <= 1'b0;
      note_a_end_irq_enable_q <= 1'b0;
      note_b_end_irq_enable_q <= 1'b0;
      time_unit_q <= 2'b00;
      tone_base_select_q <= 1'b0;
      power_window_irq_enable_q <= 1'b0;
      irq_mask_q <= 3'b000;
    end else if (wr_go) begin
      if (idx == `BZM_IDX_A_FRQ_LO) begin
        note_a_divider_q[7:0] <= wd;
      end else if (idx == `BZM_IDX_A_FRQ_HI) begin
        note_a_divider_q[11:8] <= wd[3:0];
      end else if (idx == `BZM_IDX_A_LEN) begin
        note_a_length_count_q <= wd;
      end else if (idx == `BZM_IDX_A_GAP) begin
        note_a_gap_count_q <= wd;
      end else if (idx == `BZM_IDX_B_FRQ_LO) begin
        note_b_divider_q[7:0] <= wd;
      end else if (idx == `BZM_IDX_B_FRQ_HI) begin
        note_b_divider_q[11:8] <= wd[3:0];
      end else if (idx == `BZM_IDX_B_LEN) begin
        note_b_length_count_q <= wd;
      end else if (idx == `BZM_IDX_B_GAP) begin
        note_b_gap_count_q <= wd;
      end else if (idx == `BZM_IDX_TONE_CTRL) begin
        tone_ctrl_enable_q <= wd[`BZM_TC_ENABLE];
        tone_out_invert_q <= wd[`BZM_TC_INVERT];
        note_b_end_irq_enable_q <= wd[`BZM_TC_B_IRQ_EN];
        note_a_end_irq_enable_q <= wd[`BZM_TC_A_IRQ_EN];
      end else if (idx == `BZM_IDX_PWR_WIN) begin
        power_window_count_q <= wd;
      end else if (idx == `BZM_IDX_TU_CFG) begin
        time_unit_q <= wd[`BZM_TU_HI:`BZM_TU_LO];
        tone_base_select_q <= wd[`BZM_TU_TONE_BASE_SELECT];
        power_window_irq_enable_q <= wd[`BZM_TU_PW_IRQ_EN];
      end else if (idx == `BZM_IDX_IRQ_MASK) begin
        irq_mask_q <= wd[2:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // flags: hardware set wins over software clear
  // ----------------------------------------------------------------
  wire set_a = done_a && note_a_end_irq_enable_q;
  wire set_b = done_b && note_b_end_irq_enable_q;
  wire pw_expire = pw_run_q && pw_cnt_q == 8'h00;
  wire set_pw = pw_expire;
  wire rd_stat = rd_go && idx == `BZM_IDX_IRQ_STAT;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      note_a_end_flag_q <= 1'b0;
      note_b_end_flag_q <= 1'b0;
      power_window_flag_q <= 1'b0;
      irq_stat_q <= 3'b000;
      irq <= 1'b0;
    end else begin
      // flags clear by writing zero, writing one keeps them
      note_a_end_flag_q <= set_a ||
        (note_a_end_flag_q && !(wr_tc && !wd[`BZM_TC_A_FLAG]));
      note_b_end_flag_q <= set_b ||
        (note_b_end_flag_q && !(wr_tc && !wd[`BZM_TC_B_FLAG]));
      power_window_flag_q <= set_pw ||
        (power_window_flag_q && !(wr_tu && !wd[`BZM_TU_PW_FLAG]));
      // sticky status, cleared by reading it
      irq_stat_q <= {set_pw && power_window_irq_enable_q, set_b, set_a} |
                    (rd_stat ? 3'b000 : irq_stat_q);
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ----------------------------------------------------------------
  // go commands and note sequencer
  // ----------------------------------------------------------------
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      note_a_go_q <= 1'b0;
      note_b_go_q <= 1'b0;
      state_q <= ST_IDLE;
      cur_b_q <= 1'b0;
      seg_cnt_q <= 8'h00;
    end else if (!en_next || !tone_ctrl_enable_q) begin
      // disabled: abort, drop commands; go written with enable is kept
      note_a_go_q <= en_next && wr_tc && wd[`BZM_TC_A_GO];
      note_b_go_q <= en_next && wr_tc && wd[`BZM_TC_B_GO];
      state_q <= ST_IDLE;
      cur_b_q <= 1'b0;
      seg_cnt_q <= 8'h00;
    end else begin
      note_a_go_q <= rest_a;
      note_b_go_q <= rest_b;
      if (start) begin
        cur_b_q <= next_b;
        state_q <= ST_TONE;
        seg_cnt_q <= next_b ? note_b_length_count_q : note_a_length_count_q;
      end else begin
        case (state_q)
          ST_TONE: begin
            if (seg_done) begin
              state_q <= ST_GAP;
              seg_cnt_q <= cur_b_q ? note_b_gap_count_q : note_a_gap_count_q;
            end else if (unit_tick) begin
              seg_cnt_q <= seg_cnt_q - 8'h01;
            end
          end
          ST_GAP: begin
            if (seg_done) begin
              state_q <= ST_IDLE;
            end else if (unit_tick) begin
              seg_cnt_q <= seg_cnt_q - 8'h01;
            end
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // power window timer
  // ----------------------------------------------------------------
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pw_run_q <= 1'b0;
      pw_cnt_q <= 8'h00;
      power_window_active <= 1'b0;
    end else if (!tone_ctrl_enable_q) begin
      pw_run_q <= 1'b0;
      pw_cnt_q <= 8'h00;
      power_window_active <= 1'b0;
    end else if (start) begin
      pw_run_q <= 1'b1;
      pw_cnt_q <= power_window_count_q;
      power_window_active <= 1'b1;
    end else if (pw_expire) begin
      pw_run_q <= 1'b0;
      power_window_active <= 1'b0;
    end else if (pw_run_q && pw_tick) begin
      pw_cnt_q <= pw_cnt_q - 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // tone generator: half period is divider plus one base ticks
  // ----------------------------------------------------------------
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      slow_q <= 1'b0;
      pre_q <= 5'd0;
      tone_cnt_q <= 12'h000;
      tone_q <= 1'b0;
      tone_output_pin <= 1'b0;
    end else begin
      slow_q <= slow_clock_32k;
      if (state_q != ST_TONE || start) begin
        pre_q <= 5'd0;
        tone_cnt_q <= 12'h000;
        tone_q <= 1'b0;
      end else if (pre_q == pre_lim) begin
        pre_q <= 5'd0;
        if (tone_cnt_q == div_sel) begin
          tone_cnt_q <= 12'h000;
          tone_q <= !tone_q;
        end else begin
          tone_cnt_q <= tone_cnt_q + 12'h001;
        end
      end else begin
        pre_q <= pre_q + 5'd1;
      end
      // quiet in gap, idle and disable
      tone_output_pin <= (tone_q && state_q == ST_TONE) ^ tone_out_invert_q;
    end
  end
endmodule // bzm_top

// [bzm_checker.sv]
// assertion checker for the buzzer block bus and output pins
`timescale 1ns/1ps
`include "bzm_map.vh"
module bzm_checker (
  input wire clk,
  input wire reset_n,
  input wire [17:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire slow_clock_32k,
  input wire tone_output_pin,
  input wire power_window_active,
  input wire irq
);
  // ----------------------------------------------------------------
  // shadow settings, taken as each write completes
  // ----------------------------------------------------------------
  wire wr_done = avs_write && !avs_waitrequest;
  wire rd_done = avs_read && !avs_waitrequest;
  wire [15:0] idx = avs_address[17:2];
  wire go_wr = wr_done && idx == `BZM_IDX_TONE_CTRL && avs_writedata[7] && |avs_writedata[1:0];
  reg en_q, inv_q, slow_q;
  reg [1:0] tu_q;
  reg [7:0] pw_q;
  reg [15:0] edges_q;
  wire [15:0] win_edges = ({8'h00, pw_q} << 5) << tu_q;
  // capture settings and count slow edges while the window is open
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      en_q <= 1'b0;
      inv_q <= 1'b0;
      slow_q <= 1'b0;
      tu_q <= 2'b00;
      pw_q <= 8'h00;
      edges_q <= 16'h0000;
    end else begin
      slow_q <= slow_clock_32k;
      if (wr_done && idx == `BZM_IDX_TONE_CTRL) begin
        en_q <= avs_writedata[7];
        inv_q <= avs_writedata[6];
      end
      if (wr_done && idx == `BZM_IDX_TU_CFG) tu_q <= avs_writedata[7:6];
      if (wr_done && idx == `BZM_IDX_PWR_WIN) pw_q <= avs_writedata[7:0];
      if (!power_window_active) edges_q <= 16'h0000;
      else if (slow_clock_32k && !slow_q) edges_q <= edges_q + 16'h0001;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_wait_one;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("no answer one cycle after request");
  property p_idle_wait;
    !avs_read && !avs_write |-> avs_waitrequest;
  endproperty
  a_idle_wait: assert property (p_idle_wait) else $error("waitrequest low while idle");
  property p_rd_upper;
    rd_done |-> avs_readdata[31:8] == 24'h000000;
  endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("upper read bits not zero");
  property p_quiet_off;
    (!en_q && $stable(inv_q)) [*3] |-> tone_output_pin == inv_q;
  endproperty
  a_quiet_off: assert property (p_quiet_off) else $error("pin not quiet when off");
  property p_window_off;
    !en_q [*3] |-> !power_window_active;
  endproperty
  a_window_off: assert property (p_window_off) else $error("window open when off");
  property p_window_start;
    go_wr && pw_q != 8'h00 && !power_window_active |-> ##[1:3] power_window_active;
  endproperty
  a_window_start: assert property (p_window_start) else $error("window not started");
  property p_window_len;
    $fell(power_window_active) && en_q |-> edges_q + 16'h0002 >= win_edges && edges_q <= win_edges + 16'h0002;
  endproperty
  a_window_len: assert property (p_window_len) else $error("window length wrong");
  property p_irq_clear;
    rd_done && idx == `BZM_IDX_IRQ_STAT |-> ##[1:3] !irq;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("irq stays after read");
endmodule // bzm_checker
bind bzm_top bzm_checker u_bzm_checker (.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .slow_clock_32k(slow_clock_32k), .tone_output_pin(tone_output_pin),
  .power_window_active(power_window_active), .irq(irq));

// [bzm_buzzer_model.sv]
// behavioural buzzer element that times the tone on its drive pin
`timescale 1ns/1ps
module bzm_buzzer_model #(
  parameter int MAX_HALF = 100
) (
  input wire clk,
  input wire reset_n,
  input wire clear,
  input wire tone_output_pin,
  input wire power_window_active
);
  int toggles, half_max, run, powered;
  logic last_q;
  // time gaps between pin edges in the audible band, count powered cycles
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n || clear) begin
      toggles <= 0;
      half_max <= 0;
      run <= 0;
      powered <= 0;
      last_q <= tone_output_pin;
    end else begin
      last_q <= tone_output_pin;
      run <= run + 1;
      if (power_window_active) powered <= powered + 1;
      if (tone_output_pin !== last_q) begin
        toggles <= toggles + 1;
        run <= 1;
        if (toggles > 0 && run <= MAX_HALF && run > half_max) half_max <= run;
      end
    end
  end
endmodule // bzm_buzzer_model

// [buzzer_melody_controller_bench.sv]
// self-checking bench for the buzzer block
`timescale 1ns/1ps
`include "bzm_map.vh"
`define CHK(g, e, m) begin compares++; if ((g) !== (e)) begin miscompares++; $display("FAIL %0t %s", $time, m); end end
module buzzer_melody_controller_bench;
  logic clk = 1'b0, reset_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, slow_clock_32k = 1'b0;
  logic clear = 1'b0;
  logic [1:0] slow_div = 2'b00;
  logic [17:0] avs_address = 18'h00000;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [7:0] rd;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, tone_output_pin, power_window_active, irq;
  int compares, miscompares, cyc, seed;
  localparam int SLOW_PER = 4;
  bzm_top u_bzm_top (.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .slow_clock_32k(slow_clock_32k), .tone_output_pin(tone_output_pin),
    .power_window_active(power_window_active), .irq(irq));
  bzm_buzzer_model u_bzm_buzzer_model (.clk(clk), .reset_n(reset_n), .clear(clear),
    .tone_output_pin(tone_output_pin), .power_window_active(power_window_active));
  // ----------------------------------------------------------------
  // clocks, cycle count, hang guard and bus tasks
  // ----------------------------------------------------------------
  always #2.5 clk = ~clk;
  // slow clock at a quarter rate so the shortest time unit lasts 128 cycles
  always @(posedge clk) begin
    slow_div <= slow_div + 2'b01;
    slow_clock_32k <= slow_div[1];
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      miscompares++;
      $display("FAIL %0t run timed out", $time);
      stop_test();
    end
  end
  task automatic stop_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // one access: hold until waitrequest is sampled low, then release
  task automatic bus(input logic w, input logic [15:0] idx, input logic [7:0] wd);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h000000, wd};
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask
  task automatic rdreg(input logic [15:0] idx);
    bus(1'b0, idx, 8'h00);
  endtask
  function automatic logic near(input int g, input int e, input int tol);
    return g >= e - tol && g <= e + tol;
  endfunction
  // both notes alike, then window count, unit and base
  task automatic cfg(input logic [3:0] dv, input logic [7:0] ln, gp, input logic bs,
                     input logic [1:0] tu, input logic [7:0] pw, input logic pirq);
    for (int n = 0; n < 2; n++) begin
      wr(16'hA040 + 16'(4 * n), {4'h0, dv});
      wr(16'hA041 + 16'(4 * n), 8'h00);
      wr(16'hA042 + 16'(4 * n), ln);
      wr(16'hA043 + 16'(4 * n), gp);
    end
    wr(`BZM_IDX_PWR_WIN, pw);
    wr(`BZM_IDX_TU_CFG, {tu, 1'b0, bs, 2'b00, pirq, 1'b0});
  endtask
  // start notes and poll the busy bits until both are idle
  task automatic play(input logic [7:0] ctl, output int t, output logic [1:0] fst, lst);
    int t0;
    fst = 2'b00;
    lst = 2'b00;
    clear <= 1'b1;
    wr(`BZM_IDX_TONE_CTRL, ctl);
    clear <= 1'b0;
    t0 = cyc;
    do begin
      rdreg(`BZM_IDX_TONE_CTRL);
      if (rd[1:0] !== 2'b00) lst = rd[1:0];
      if (fst === 2'b00) fst = rd[1:0];
    end while (rd[1:0] !== 2'b00 && cyc - t0 < 20000);
    t = cyc - t0;
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] v, ctl, len, gap;
    logic [3:0] div;
    logic [1:0] tu, fst, lst, fl;
    logic base, inv, ie;
    int t, unit, half, nn;
    seed = $urandom(27);
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 13; i++) begin
      rdreg(16'hA040 + 16'(i));
      `CHK(rd, 8'h00, "reset value")
    end
    for (int i = 0; i < 10; i++) begin
      v = $urandom;
      if (i == 1 || i == 5) v = v & 8'h0F;
      if (i != 8) begin
        wr(16'hA040 + 16'(i), v);
        rdreg(16'hA040 + 16'(i));
        `CHK(rd, v, "read back")
      end
    end
    wr(16'hA04F, 8'hFF);
    rdreg(16'hA04F);
    `CHK(rd, 8'h00, "unmapped index")
    wr(`BZM_IDX_IRQ_MASK, 8'h07);
    $display("test registers done");
    for (int k = 0; k < 6; k++) begin
      tu = 2'(k % 4);
      base = $urandom;
      div = 4'($urandom % 2);
      inv = $urandom;
      len = 8'(2 + $urandom % 2);
      gap = 8'(1 + $urandom % 2);
      ie = (k != 4);
      nn = (k == 2) ? 2 : 1;
      ctl = {1'b1, inv, ie, ie, 2'b00, (k == 2) ? 2'b11 : ((k % 2) ? 2'b10 : 2'b01)};
      unit = (32 << tu) * SLOW_PER;
      half = (div + 1) * (16 << base);
      if (k == 5) wr(`BZM_IDX_IRQ_MASK, 8'h00);
      cfg(div, len, gap, base, tu, len, ie);
      play(ctl, t, fst, lst);
      `CHK(near(t, nn * (len + gap) * unit, 16), 1'b1, "note time")
      `CHK(fst, (k == 2) ? 2'b01 : ctl[1:0], "first busy")
      `CHK(lst, (k == 2) ? 2'b10 : ctl[1:0], "last busy")
      `CHK(u_bzm_buzzer_model.half_max, half, "half period")
      `CHK(near(u_bzm_buzzer_model.toggles, nn * len * unit / half, 4), 1'b1, "edges")
      `CHK(near(u_bzm_buzzer_model.powered, nn * len * unit, 12), 1'b1, "window")
      `CHK(tone_output_pin, inv, "quiet level")
      fl = ie ? ctl[1:0] : 2'b00;
      rdreg(`BZM_IDX_TONE_CTRL);
      `CHK(rd[3:2], fl, "end flags")
      `CHK(irq, ie && k != 5, "irq level")
      rdreg(`BZM_IDX_IRQ_STAT);
      `CHK(rd[2:0], {ie, fl}, "irq status")
      rdreg(`BZM_IDX_TU_CFG);
      `CHK(rd[0], 1'b1, "window flag")
      wr(`BZM_IDX_TONE_CTRL, (ctl & 8'hF0) | 8'h0C);
      rdreg(`BZM_IDX_TONE_CTRL);
      `CHK(rd[3:2], fl, "flags kept")
      wr(`BZM_IDX_TONE_CTRL, ctl & 8'hF0);
      rdreg(`BZM_IDX_TONE_CTRL);
      `CHK(rd[3:0], 4'h0, "flags cleared")
      `CHK(irq, 1'b0, "irq after read")
      $display("test note case %0d done", k);
    end
    cfg(4'h0, 8'h08, 8'h02, 1'b0, 2'b00, 8'h08, 1'b1);
    wr(`BZM_IDX_TONE_CTRL, 8'h81);
    repeat (100) @(posedge clk);
    wr(`BZM_IDX_TONE_CTRL, 8'h40);
    repeat (4) @(posedge clk);
    `CHK(tone_output_pin, 1'b1, "inverted quiet when off")
    `CHK(power_window_active, 1'b0, "window when off")
    wr(`BZM_IDX_TONE_CTRL, 8'h41);
    wr(`BZM_IDX_TONE_CTRL, 8'hC0);
    clear <= 1'b1;
    rdreg(`BZM_IDX_TONE_CTRL);
    clear <= 1'b0;
    `CHK(rd[1:0], 2'b00, "busy after abort")
    repeat (300) @(posedge clk);
    `CHK(u_bzm_buzzer_model.toggles, 0, "silent after zero go")
    `CHK(power_window_active, 1'b0, "no window after zero go")
    $display("test abort done");
    // b armed while a still plays follows straight after it
    cfg(4'h0, 8'h02, 8'h01, 1'b0, 2'b00, 8'h02, 1'b0);
    wr(`BZM_IDX_TONE_CTRL, 8'h81);
    play(8'h82, t, fst, lst);
    `CHK(fst, 2'b01, "armed b waits for a")
    `CHK(lst, 2'b10, "armed b follows a")
    `CHK(near(t, 2 * 3 * 32 * SLOW_PER, 16), 1'b1, "melody time")
    $display("test melody done");
    stop_test();
  end
endmodule // buzzer_melody_controller_bench
